// file: common/uart_cmd_pkg.sv
package uart_cmd_pkg;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_COMMAND = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;

  // ------------------------------------------------------------
  // Command register fields
  // ------------------------------------------------------------
  localparam int TX_CMD_LSB = 2;
  localparam int RX_CMD_LSB = 0;
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_ENABLE = 2'h1;
  localparam logic [1:0] CMD_DISABLE = 2'h2;

  // ------------------------------------------------------------
  // Mode register fields
  // ------------------------------------------------------------
  localparam int MODE_PM_LSB = 0;
  localparam int MODE_MODEM_BIT = 2;
  localparam int MODE_AC97_BIT = 3;
  localparam int MODE_CHAN_LSB = 4;
  localparam int MODE_WIDTH = 6;
  localparam logic [5:0] MODE_RESET = 6'h00;
  localparam logic [1:0] PM_MULTIDROP = 2'h3;
  localparam logic [1:0] CHAN_NORMAL = 2'h0;
  localparam logic [1:0] CHAN_ECHO = 2'h1;
  localparam logic [1:0] CHAN_LOCAL_LOOP = 2'h2;
  localparam logic [1:0] CHAN_REMOTE_LOOP = 2'h3;

  // ------------------------------------------------------------
  // Status register bits
  // ------------------------------------------------------------
  localparam int STAT_RX_EN_BIT = 0;
  localparam int STAT_TX_EN_BIT = 1;
  localparam int STAT_TX_RDY_BIT = 2;
  localparam int STAT_TX_EMP_BIT = 3;
  localparam int STAT_RX_ACT_BIT = 4;
  localparam int STAT_TX_ACT_BIT = 5;

endpackage

// file: core/uart_txrx_enable_commands.sv
`timescale 1ns/1ps
// What this block does
// - Transmitter code 00 keeps transmitter state
// - Transmitter enable in UART mode sets empty and ready flags
// - Enable while enabled changes nothing
// - Modem enable: empty set at first sync
// - AC97 empty needs fifo empty, ready, sync
// - Transmitter disable stops and clears empty; ready is cleared in UART mode
// - Character in flight finishes before going idle
// - Disable while disabled changes nothing
// - Modem disable keeps ready unless echo/remote loop
// - Modem accepts fifo writes while disabled
// - Receiver code 00 keeps receiver state
// - Receiver enable hunts start bit unless multidrop
// - Receiver enable while enabled changes nothing
// - UART receiver disable drops partial character immediately
// - Receiver disable leaves transmitter ready and empty flags untouched
// - Local loop or multidrop keeps receiver running
// - Receiver disable while disabled changes nothing
// - Modem receiver finishes character before stopping
module uart_txrx_enable_commands
  import uart_cmd_pkg::*;
(
  input wire logic clk, // System clock, 100 MHz
  input wire logic rst_b, // Asynchronous reset, active low
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic hsel, // AHB slave select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write strobe
  input wire logic [2:0] hsize, // AHB transfer size
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic hreadyout, // AHB slave ready
  output logic [31:0] hrdata, // AHB read data
  output logic hresp, // AHB response, always OKAY
  input wire logic tx_shifting, // Transmit shifter is sending a character
  input wire logic rx_in_char, // Receive shifter is inside a character
  input wire logic frame_sync, // Modem frame sync pulse
  input wire logic codec_ready, // Receiver saw the coded ready condition
  input wire logic tx_fifo_empty, // Transmit FIFO holds nothing
  input wire logic tx_fifo_write, // Request to write the transmit FIFO
  output logic tx_write_ok, // Transmit FIFO write accepted
  output logic tx_active, // Transmitter operating
  output logic rx_active, // Receiver operating
  output logic rx_hunt, // Pulse: receiver to search for start bit
  output logic rx_drop, // Pulse: discard partial character
  output logic tx_ready_flag, // Transmitter ready status
  output logic tx_empty_flag // Transmitter empty status
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic ph_valid;
    logic ph_wr;
    logic [7:0] ph_addr;
    logic [31:0] rdata;
    logic [MODE_WIDTH-1:0] mode;
    logic tx_en;
    logic tx_drain;
    logic tx_rdy;
    logic tx_emp;
    logic tx_arm;
    logic rx_en;
    logic rx_drain;
    logic rx_hunt;
    logic rx_drop;
  } state_t;

  localparam state_t STATE_RESET = '{
    ph_valid: 1'b0, ph_wr: 1'b0, ph_addr: 8'h00, rdata: 32'h0000_0000,
    mode: MODE_RESET, tx_en: 1'b0, tx_drain: 1'b0, tx_rdy: 1'b0,
    tx_emp: 1'b0, tx_arm: 1'b0, rx_en: 1'b0, rx_drain: 1'b0,
    rx_hunt: 1'b0, rx_drop: 1'b0};

  state_t s_q;
  state_t s_d;

  logic [1:0] pm;
  logic [1:0] chan;
  logic modem;
  logic ac97;
  logic cmd_wr;
  logic mode_wr;
  logic [1:0] tx_cmd;
  logic [1:0] rx_cmd;
  logic addr_phase;
  logic rx_keep;
  logic [31:0] status_word;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  assign pm = s_q.mode[MODE_PM_LSB +: 2];
  assign chan = s_q.mode[MODE_CHAN_LSB +: 2];
  assign modem = s_q.mode[MODE_MODEM_BIT];
  assign ac97 = s_q.mode[MODE_AC97_BIT];
  // Local loop-back and multidrop keep the receiver running
  assign rx_keep = (chan == CHAN_LOCAL_LOOP) || (pm == PM_MULTIDROP);
  assign addr_phase = hsel && htrans[1] && hready;
  // Command fields only live during the one write data phase
  assign cmd_wr = ce && s_q.ph_valid && s_q.ph_wr && (s_q.ph_addr == OFS_COMMAND);
  assign mode_wr = ce && s_q.ph_valid && s_q.ph_wr && (s_q.ph_addr == OFS_MODE);
  assign tx_cmd = cmd_wr ? hwdata[TX_CMD_LSB +: 2] : CMD_NONE;
  assign rx_cmd = cmd_wr ? hwdata[RX_CMD_LSB +: 2] : CMD_NONE;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[STAT_RX_EN_BIT] = s_q.rx_en;
    status_word[STAT_TX_EN_BIT] = s_q.tx_en;
    status_word[STAT_TX_RDY_BIT] = s_q.tx_rdy;
    status_word[STAT_TX_EMP_BIT] = s_q.tx_emp;
    status_word[STAT_RX_ACT_BIT] = rx_active;
    status_word[STAT_TX_ACT_BIT] = tx_active;
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.rx_hunt = 1'b0;
    s_d.rx_drop = 1'b0;

    // Bus address phase; writes land in the following data phase
    s_d.ph_valid = addr_phase;
    s_d.ph_wr = hwrite;
    s_d.ph_addr = haddr[7:0];
    if (addr_phase && !hwrite) begin
      case (haddr[7:0])
        OFS_MODE: s_d.rdata = {{(32-MODE_WIDTH){1'b0}}, s_q.mode};
        OFS_STATUS: s_d.rdata = status_word;
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
    if (mode_wr) begin
      s_d.mode = hwdata[MODE_WIDTH-1:0];
    end

    // Drains end as soon as the shifter finishes its character
    if (s_q.tx_drain && !tx_shifting) begin
      s_d.tx_drain = 1'b0;
    end
    if (s_q.rx_drain && !rx_in_char) begin
      s_d.rx_drain = 1'b0;
    end

    // Transmitter; code 00 and reserved 11 fall through untouched
    case (tx_cmd)
      CMD_ENABLE: begin
        if (!s_q.tx_en) begin
          s_d.tx_en = 1'b1;
          s_d.tx_drain = 1'b0;
          if (modem) begin
            s_d.tx_arm = 1'b1;
          end else begin
            s_d.tx_rdy = 1'b1;
            s_d.tx_emp = 1'b1;
          end
        end
      end
      CMD_DISABLE: begin
        if (s_q.tx_en) begin
          s_d.tx_en = 1'b0;
          s_d.tx_arm = 1'b0;
          s_d.tx_drain = tx_shifting;
          s_d.tx_emp = 1'b0;
          if (!modem || chan == CHAN_ECHO || chan == CHAN_REMOTE_LOOP) begin
            s_d.tx_rdy = 1'b0;
          end
        end
      end
      default: begin
        s_d.tx_en = s_q.tx_en;
      end
    endcase

    // Any sample written before the first sync cancels the arm
    if (s_q.tx_arm && tx_write_ok) begin
      s_d.tx_arm = 1'b0;
    end
    // Set after the clears so a same-cycle event is not lost
    if (modem && s_q.tx_arm && s_q.tx_en && frame_sync) begin
      s_d.tx_arm = 1'b0;
      if (tx_fifo_empty && !tx_fifo_write && (!ac97 || codec_ready)) begin
        s_d.tx_emp = 1'b1;
      end
    end

    // Receiver; transmitter ready and empty flags are never touched here
    case (rx_cmd)
      CMD_ENABLE: begin
        if (!s_q.rx_en && pm != PM_MULTIDROP) begin
          s_d.rx_en = 1'b1;
          s_d.rx_drain = 1'b0;
          s_d.rx_hunt = 1'b1;
        end
      end
      CMD_DISABLE: begin
        if (s_q.rx_en && !rx_keep) begin
          s_d.rx_en = 1'b0;
          if (modem) begin
            s_d.rx_drain = rx_in_char;
          end else begin
            s_d.rx_drop = rx_in_char;
          end
        end
      end
      default: begin
        s_d.rx_en = s_q.rx_en;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= STATE_RESET;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Zero wait states: every transfer completes in one data phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_q.rdata;
  assign tx_active = s_q.tx_en || s_q.tx_drain;
  assign rx_active = s_q.rx_en || s_q.rx_drain;
  assign rx_hunt = s_q.rx_hunt;
  assign rx_drop = s_q.rx_drop;
  assign tx_ready_flag = s_q.tx_rdy;
  assign tx_empty_flag = s_q.tx_emp;
  // UART mode refuses FIFO writes while disabled
  assign tx_write_ok = tx_fifo_write && (modem || s_q.tx_en);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  a_tx_enable_flags: assert property (
    tx_cmd == CMD_ENABLE && !s_q.tx_en && !modem
    |=> s_q.tx_en && tx_ready_flag && tx_empty_flag)
    else $error("tx enable did not set flags");

  a_tx_modem_noset: assert property (
    tx_cmd == CMD_ENABLE && !s_q.tx_en && modem && !tx_ready_flag
    |=> !tx_ready_flag && s_q.tx_en)
    else $error("modem tx enable touched ready");

  a_tx_emp_sync: assert property (
    ce && modem && s_q.tx_arm && s_q.tx_en && frame_sync && tx_fifo_empty
    && !tx_fifo_write && (!ac97 || codec_ready) |=> tx_empty_flag)
    else $error("empty not set at frame sync");

  a_tx_disable_clear: assert property (
    tx_cmd == CMD_DISABLE && s_q.tx_en && !modem
    |=> !s_q.tx_en && !tx_ready_flag && !tx_empty_flag)
    else $error("tx disable left flags set");

  a_tx_drain_hold: assert property (
    tx_cmd == CMD_DISABLE && s_q.tx_en && tx_shifting
    |=> tx_active)
    else $error("tx stopped mid character");

  a_tx_modem_keep: assert property (
    tx_cmd == CMD_DISABLE && modem && chan == CHAN_NORMAL
    |=> tx_ready_flag == $past(tx_ready_flag))
    else $error("modem tx disable changed ready");

  a_tx_fifo_gate: assert property (
    !modem && !s_q.tx_en |-> !tx_write_ok)
    else $error("fifo write taken while disabled");

  a_rx_enable_hunt: assert property (
    rx_cmd == CMD_ENABLE && !s_q.rx_en && pm != PM_MULTIDROP
    |=> s_q.rx_en && rx_hunt)
    else $error("rx enable did not hunt");

  a_rx_multidrop_block: assert property (
    rx_cmd == CMD_ENABLE && !s_q.rx_en && pm == PM_MULTIDROP
    |=> !s_q.rx_en && !rx_hunt)
    else $error("rx enabled in multidrop");

  a_rx_disable_drop: assert property (
    rx_cmd == CMD_DISABLE && s_q.rx_en && !rx_keep && !modem && rx_in_char
    |=> !rx_active && rx_drop)
    else $error("rx disable kept character");

  a_rx_loop_keep: assert property (
    rx_cmd == CMD_DISABLE && s_q.rx_en && rx_keep |=> s_q.rx_en)
    else $error("rx stopped in loop or multidrop");

  a_rx_modem_finish: assert property (
    rx_cmd == CMD_DISABLE && s_q.rx_en && !rx_keep && modem && rx_in_char
    |=> rx_active && !rx_drop)
    else $error("modem rx cut character");

  a_tx_hold_state: assert property (
    tx_cmd == CMD_NONE |=> $stable(s_q.tx_en))
    else $error("tx state moved without command");

  a_tx_enable_again: assert property (
    tx_cmd == CMD_ENABLE && s_q.tx_en && !frame_sync
    |=> s_q.tx_en && $stable(tx_ready_flag) && $stable(tx_empty_flag))
    else $error("repeat tx enable changed state");

  a_tx_disable_again: assert property (
    tx_cmd == CMD_DISABLE && !s_q.tx_en
    |=> !s_q.tx_en && $stable(tx_ready_flag) && $stable(tx_empty_flag))
    else $error("repeat tx disable changed state");

  a_tx_modem_empty: assert property (
    tx_cmd == CMD_DISABLE && s_q.tx_en && modem && !frame_sync
    |=> !s_q.tx_en && !tx_empty_flag)
    else $error("modem tx disable left empty set");

  a_tx_echo_clear: assert property (
    tx_cmd == CMD_DISABLE && s_q.tx_en && modem
    && (chan == CHAN_ECHO || chan == CHAN_REMOTE_LOOP) |=> !tx_ready_flag)
    else $error("echo or remote loop kept ready");

  a_tx_ac97_wait: assert property (
    modem && ac97 && !codec_ready && !tx_empty_flag |=> !tx_empty_flag)
    else $error("empty set without codec ready");

  a_tx_drain_end: assert property (
    ce && s_q.tx_drain && !tx_shifting && !s_q.tx_en && tx_cmd != CMD_ENABLE
    |=> !tx_active)
    else $error("tx stayed active after character");

  a_rx_drain_end: assert property (
    ce && s_q.rx_drain && !rx_in_char && !s_q.rx_en && rx_cmd != CMD_ENABLE
    |=> !rx_active)
    else $error("rx stayed active after character");

  a_rx_hold_state: assert property (
    rx_cmd == CMD_NONE |=> $stable(s_q.rx_en))
    else $error("rx state moved without command");

  a_rx_enable_again: assert property (
    rx_cmd == CMD_ENABLE && s_q.rx_en |=> s_q.rx_en && !rx_hunt)
    else $error("repeat rx enable hunted again");

  a_rx_disable_again: assert property (
    rx_cmd == CMD_DISABLE && !s_q.rx_en |=> !s_q.rx_en && !rx_drop)
    else $error("repeat rx disable dropped data");

  a_rx_status_keep: assert property (
    rx_cmd == CMD_DISABLE && tx_cmd == CMD_NONE && !frame_sync
    |=> $stable(tx_ready_flag) && $stable(tx_empty_flag) && $stable(s_q.mode))
    else $error("rx disable touched status");

  a_rx_hunt_once: assert property (
    ce && rx_hunt |=> !rx_hunt)
    else $error("hunt pulse held past one cycle");

  c_tx_uart_cycle: cover property (
    tx_cmd == CMD_ENABLE && !modem ##[1:50] tx_cmd == CMD_DISABLE);
  c_tx_modem_sync: cover property (
    modem && s_q.tx_arm && frame_sync ##1 tx_empty_flag);
  c_rx_hunt: cover property (rx_hunt);
  c_rx_drain: cover property (s_q.rx_drain ##1 !s_q.rx_drain);
  c_rx_drop: cover property (rx_drop);

endmodule

// file: testbench/serial_far_end.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Line partner: shifters and frame sync
// ------------------------------------------------------------
module serial_far_end #(
  parameter int CHAR_CYCLES = 12 // Clocks per character
) (
  input wire logic clk, // System clock
  input wire logic rst_b, // Asynchronous reset, active low
  input wire logic tx_go, // Start one outgoing character
  input wire logic rx_go, // Start one incoming character
  input wire logic sync_go, // Ask for one frame sync
  output logic tx_shifting, // Outgoing character on the line
  output logic rx_in_char, // Incoming character on the line
  output logic frame_sync // One-cycle frame sync
);
  logic [7:0] tx_cnt_q;
  logic [7:0] rx_cnt_q;

  // Sync only on request, so the bench knows when flags may move
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_cnt_q <= 8'h00;
      rx_cnt_q <= 8'h00;
      frame_sync <= 1'b0;
    end else begin
      tx_cnt_q <= tx_go ? 8'(CHAR_CYCLES) : tx_cnt_q - 8'(tx_cnt_q != 8'h00);
      rx_cnt_q <= rx_go ? 8'(CHAR_CYCLES) : rx_cnt_q - 8'(rx_cnt_q != 8'h00);
      frame_sync <= sync_go;
    end
  end

  assign tx_shifting = tx_cnt_q != 8'h00;
  assign rx_in_char = rx_cnt_q != 8'h00;
endmodule

// file: testbench/uart_txrx_enable_commands_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module uart_txrx_enable_commands_bench import uart_cmd_pkg::*;;
  logic clk, rst_b, ce, hsel, hwrite, hreadyout, hresp;
  logic tx_active, rx_active, rx_hunt, rx_drop, tx_ready_flag, tx_empty_flag;
  logic rd_ph = 1'b0;
  logic rd_st = 1'b0;
  logic [31:0] exp_w;
  logic [1:0] pulse_w;
  logic [1:0] ev_q[$];
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic tx_shifting, rx_in_char, frame_sync, codec_ready, tx_fifo_empty, tx_fifo_write;
  logic tx_go, rx_go, sync_go, tx_write_ok;
  logic [5:0] mval;
  logic [31:0] exp_q[$];
  int fails = 0;
  int checked = 0;

  uart_txrx_enable_commands dut (.clk(clk), .rst_b(rst_b), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .tx_shifting(tx_shifting), .rx_in_char(rx_in_char), .frame_sync(frame_sync),
    .codec_ready(codec_ready), .tx_fifo_empty(tx_fifo_empty),
    .tx_fifo_write(tx_fifo_write), .tx_write_ok(tx_write_ok), .tx_active(tx_active),
    .rx_active(rx_active), .rx_hunt(rx_hunt), .rx_drop(rx_drop),
    .tx_ready_flag(tx_ready_flag), .tx_empty_flag(tx_empty_flag));

  serial_far_end far (.clk(clk), .rst_b(rst_b), .tx_go(tx_go), .rx_go(rx_go),
    .sync_go(sync_go), .tx_shifting(tx_shifting), .rx_in_char(rx_in_char),
    .frame_sync(frame_sync));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ------------------------------------------------------------
  // Bus master and read monitor
  // ------------------------------------------------------------
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [5:0] e);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    if (!w) exp_q.push_back({26'h000_0000, e});
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [5:0] d);
    bus(a, 1'b1, {26'h000_0000, d}, 6'h00);
  endtask

  task automatic rd(input logic [7:0] a, input logic [5:0] e);
    bus(a, 1'b0, 32'h0000_0000, e);
  endtask

  // Raise one frame sync, then let the flag update land
  task automatic sync_pulse();
    sync_go <= 1'b1;
    @(posedge clk);
    sync_go <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic wait_lvl(input logic use_rx, input logic lvl);
    for (int i = 0; i < 50 && (use_rx ? rx_in_char : tx_shifting) !== lvl; i++)
      @(posedge clk);
  endtask

  // Pop once: the macro names its expected value twice
  always @(posedge clk) begin
    if (rd_ph && hreadyout && exp_q.size() > 0) begin
      exp_w = exp_q.pop_front();
      `CHK({hresp, hrdata}, {1'b0, exp_w})
      if (rd_st) `CHK({tx_active, rx_active, tx_empty_flag, tx_ready_flag}, exp_w[5:2])
    end
    if (rx_hunt || rx_drop) begin
      pulse_w = (ev_q.size() > 0) ? ev_q.pop_front() : 2'b00;
      `CHK({rx_hunt, rx_drop}, pulse_w)
    end
    rd_ph <= hsel & htrans[1] & ~hwrite & hreadyout;
    rd_st <= haddr[7:0] == OFS_STATUS;
  end

  task automatic close_out();
    if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    close_out();
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    rst_b = 1'b0; ce = 1'b1; hsel = 1'b0; haddr = 32'h0000_0000; htrans = 2'h0;
    hwrite = 1'b0; hwdata = 32'h0000_0000; codec_ready = 1'b0;
    tx_fifo_empty = 1'b1; tx_fifo_write = 1'b0; tx_go = 1'b0; rx_go = 1'b0;
    sync_go = 1'b0;
    void'($urandom(32'h0000_4c97));
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(OFS_STATUS, 6'h00);
    rd(OFS_COMMAND, 6'h00);
    rd(8'h0c, 6'h00);
    mval = 6'($urandom());
    wr(OFS_MODE, mval);
    rd(OFS_MODE, mval);
    wr(OFS_MODE, MODE_RESET);
    wr(OFS_COMMAND, 6'h04);
    rd(OFS_STATUS, 6'h2e);
    wr(OFS_COMMAND, 6'h04);
    rd(OFS_STATUS, 6'h2e);
    wr(OFS_COMMAND, 6'h00);
    rd(OFS_STATUS, 6'h2e);
    ev_q.push_back(2'b10);
    wr(OFS_COMMAND, 6'h01);
    rd(OFS_STATUS, 6'h3f);
    wr(OFS_COMMAND, 6'h01);
    rd(OFS_STATUS, 6'h3f);
    wr(OFS_COMMAND, 6'h00);
    rd(OFS_STATUS, 6'h3f);
    wr(OFS_COMMAND, 6'h02);
    rd(OFS_STATUS, 6'h2e);
    wr(OFS_COMMAND, 6'h02);
    rd(OFS_STATUS, 6'h2e);
    tx_go <= 1'b1;
    @(posedge clk);
    tx_go <= 1'b0;
    wait_lvl(1'b0, 1'b1);
    wr(OFS_COMMAND, 6'h08);
    rd(OFS_STATUS, 6'h20);
    wait_lvl(1'b0, 1'b0);
    repeat (2) @(posedge clk);
    rd(OFS_STATUS, 6'h00);
    wr(OFS_COMMAND, 6'h08);
    rd(OFS_STATUS, 6'h00);
    wr(OFS_MODE, 6'h20);
    ev_q.push_back(2'b10);
    wr(OFS_COMMAND, 6'h05);
    wr(OFS_COMMAND, 6'h02);
    rd(OFS_STATUS, 6'h3f);
    wr(OFS_MODE, 6'h03);
    wr(OFS_COMMAND, 6'h0a);
    wr(OFS_MODE, MODE_RESET);
    wr(OFS_COMMAND, 6'h06);
    rd(OFS_STATUS, 6'h2e);
    wr(OFS_MODE, 6'h03);
    wr(OFS_COMMAND, 6'h01);
    rd(OFS_STATUS, 6'h2e);
    wr(OFS_MODE, MODE_RESET);
    wr(OFS_COMMAND, 6'h04);
    wr(OFS_MODE, 6'h04);
    wr(OFS_COMMAND, 6'h08);
    rd(OFS_STATUS, 6'h04);
    tx_fifo_write <= 1'b1;
    @(posedge clk);
    `CHK(tx_write_ok, 1'b1)
    tx_fifo_write <= 1'b0;
    wr(OFS_COMMAND, 6'h04);
    rd(OFS_STATUS, 6'h26);
    sync_pulse();
    rd(OFS_STATUS, 6'h2e);
    wr(OFS_MODE, 6'h14);
    wr(OFS_COMMAND, 6'h08);
    rd(OFS_STATUS, 6'h00);
    wr(OFS_MODE, 6'h0c);
    wr(OFS_COMMAND, 6'h04);
    sync_pulse();
    rd(OFS_STATUS, 6'h22);
    wr(OFS_COMMAND, 6'h08);
    codec_ready <= 1'b1;
    wr(OFS_COMMAND, 6'h04);
    sync_pulse();
    rd(OFS_STATUS, 6'h2a);
    wr(OFS_COMMAND, 6'h08);
    wr(OFS_MODE, 6'h04);
    ev_q.push_back(2'b10);
    wr(OFS_COMMAND, 6'h01);
    rx_go <= 1'b1;
    @(posedge clk);
    rx_go <= 1'b0;
    wait_lvl(1'b1, 1'b1);
    wr(OFS_COMMAND, 6'h02);
    rd(OFS_STATUS, 6'h10);
    wait_lvl(1'b1, 1'b0);
    repeat (2) @(posedge clk);
    rd(OFS_STATUS, 6'h00);
    wr(OFS_MODE, MODE_RESET);
    ev_q.push_back(2'b10);
    wr(OFS_COMMAND, 6'h01);
    rx_go <= 1'b1;
    @(posedge clk);
    rx_go <= 1'b0;
    wait_lvl(1'b1, 1'b1);
    ev_q.push_back(2'b01);
    wr(OFS_COMMAND, 6'h02);
    rd(OFS_STATUS, 6'h00);
    // Clock enable low: the write below must be lost
    tx_fifo_write <= 1'b1;
    ce <= 1'b0;
    @(posedge clk);
    `CHK(tx_write_ok, 1'b0)
    tx_fifo_write <= 1'b0;
    wr(OFS_COMMAND, 6'h04);
    ce <= 1'b1;
    rd(OFS_STATUS, 6'h00);
    `CHK(ev_q.size(), 0)
    repeat (2) @(posedge clk);
    close_out();
  end
endmodule
